// file: design/acm_map.vh
// Purpose: Constants of the serial modem adapter: register selects, fields, timing.
// Assumes: 40 MHz clk; 16 samples per serial bit.
// Notes:   Definitions only.
`ifndef ACM_MAP_VH
`define ACM_MAP_VH

// Register select codes {high, low}
`define ACM_SEL_DATA      2'h0
`define ACM_SEL_STATUS    2'h1
`define ACM_SEL_COMMAND   2'h2
`define ACM_SEL_CONTROL   2'h3

// Reset values
`define ACM_CTRL_RST      8'h00
`define ACM_CMD_RST       8'h00
`define ACM_CMD_PRST_MASK 8'hE0

// line_format_control fields
`define ACM_CTL_BAUD_LO   0
`define ACM_CTL_BAUD_HI   3
`define ACM_CTL_RXSRC     4
`define ACM_CTL_WLEN_LO   5
`define ACM_CTL_WLEN_HI   6
`define ACM_CTL_STOP      7

// line_function_command fields
`define ACM_CMD_DTR       0
`define ACM_CMD_RXIRQ_DIS 1
`define ACM_CMD_TXC_LO    2
`define ACM_CMD_TXC_HI    3
`define ACM_CMD_PAR_EN    5
`define ACM_CMD_PAR_LO    6
`define ACM_CMD_PAR_HI    7
`define ACM_TXC_RTS_IRQ   2'h1
`define ACM_TXC_RTS_HIGH  2'h0

// line_status fields
`define ACM_ST_PAR        0
`define ACM_ST_FRM        1
`define ACM_ST_OVR        2
`define ACM_ST_RXF        3
`define ACM_ST_TXE        4
`define ACM_ST_DCD        5
`define ACM_ST_DSR        6
`define ACM_ST_IRQ        7

// Parity modes
`define ACM_PAR_ODD       2'h0
`define ACM_PAR_EVEN      2'h1
`define ACM_PAR_MARK      2'h2

// Serial timing
`define ACM_CLK_HZ        40000000
`define ACM_OVERSAMPLE    16
`define ACM_TICKS_BIT     5'h10
`define ACM_TICKS_HALF    5'h08
`define ACM_FIFO_DEPTH    32
`define ACM_FIFO_AW       5

// Baud rates (times 100) for selects 1..15; select 0 uses the external 16x clock
`define ACM_BAUD100_1     5000
`define ACM_BAUD100_2     7500
`define ACM_BAUD100_3     10992
`define ACM_BAUD100_4     13458
`define ACM_BAUD100_5     15000
`define ACM_BAUD100_6     30000
`define ACM_BAUD100_7     60000
`define ACM_BAUD100_8     120000
`define ACM_BAUD100_9     180000
`define ACM_BAUD100_10    240000
`define ACM_BAUD100_11    360000
`define ACM_BAUD100_12    480000
`define ACM_BAUD100_13    720000
`define ACM_BAUD100_14    960000
`define ACM_BAUD100_15    1920000
// Clock cycles per 16x tick, rounded down
`define ACM_DIV(b100)     (`ACM_CLK_HZ / (`ACM_OVERSAMPLE * (b100) / 100))

`endif

// file: design/acm_fifo.v
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; WIDTH and DEPTH set by instance, DEPTH a power of two.
// Notes:   Full and empty are exact; in_ready is low while full.
`timescale 1ns/10ps
module acm_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,       // Clock
  input  wire             rst_b,     // Async reset, active low
  input  wire             in_valid,  // Write request
  output wire             in_ready,  // Room available
  input  wire [WIDTH-1:0] in_data,   // Write data
  output wire             out_valid, // Data available
  input  wire             out_ready, // Reader takes data
  output wire [WIDTH-1:0] out_data   // Head of queue
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // acm_fifo

// file: design/acm_adapter.v
// Purpose: Asynchronous serial adapter between a byte register port and a modem.
// Assumes: All inputs synchronous to clk; bus_strobe marks one access per pulse.
// Notes:   Received characters queue in a 32-entry FIFO ahead of receive_holding.
// Operation
// RULE_01: Transmitter runs only while clear-to-send is low; high disables it.
// RULE_02: Terminal-ready output follows command bit 0; low means enabled.
// RULE_03: With command bit 0 set, data-set-ready change interrupts; status bit 6 shows it.
// RULE_04: Data-set-ready never affects transmit or receive.
// RULE_05: With command bit 0 set, carrier-detect change interrupts; status bit 5 shows it.
// RULE_06: Receiver works only while carrier-detect is low; transmit ignores it.
// RULE_07: Modem drives data-set-ready and carrier-detect to definite levels.
// RULE_08: Control bits 0-3 select the transmit baud divisor.
// RULE_09: Receiver on internal baud rate makes receive clock pin output the 16x clock.
// RULE_10: Control register sets word length, stop bits and clock source.
// RULE_11: Error flags clear after a data read and a later error-free character.
// RULE_12: Parity, framing and overrun raise no interrupt.
// RULE_13: Receive-full sets on a held character, clears on data read.
// RULE_14: Transmit-empty sets when holding empty, clears on data write.
// RULE_15: Transmit bit 0 first; unused high bits ignored.
// RULE_16: Receive bit 0 first; parity stripped; unused bits read zero.
// RULE_17: Selects: 00 data, 01 reset/status, 10 command, 11 control.
// RULE_18: Interrupt output is open-drain, pulled low while pending.
// RULE_19: Hardware reset clears internal registers.
// RULE_20: External receive clock runs at sixteen times the bit rate.
// RULE_21: Character arriving with no room sets overrun; held data kept.
// RULE_22: Frame is low start, data, optional parity, high stop bits; idle high.
`timescale 1ns/10ps
`include "acm_map.vh"
module acm_adapter (
  input  wire       clk,                  // 40 MHz clock
  input  wire       rst_b,                // Hardware clear, active low
  input  wire       chip_sel,             // Adapter selected
  input  wire       bus_strobe,           // One-cycle access pulse
  input  wire       read_not_write,       // 1 read, 0 write
  input  wire       register_select_low,  // Register select bit 0
  input  wire       register_select_high, // Register select bit 1
  input  wire [7:0] data_in,              // Write data
  output wire [7:0] data_out,             // Read data
  output wire       data_oe,              // Data bus driven
  output wire       irq_out,              // Interrupt pin level when driven
  output wire       irq_oe,               // Interrupt pin pulled low
  output wire       txd,                  // Serial transmit data
  input  wire       rxd,                  // Serial receive data
  input  wire       cts_n,                // Clear to send, active low
  input  wire       dsr_n,                // Data set ready, active low
  input  wire       dcd_n,                // Carrier detect, active low
  output wire       rts_n,                // Request to send, active low
  output wire       dtr_n,                // Terminal ready, active low
  input  wire       receive_clock_pin_in, // 16x receive clock in
  output wire       receive_clock_pin_out,// 16x receive clock out
  output wire       receive_clock_pin_oe  // Receive clock pin driven
);
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;
  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS  = 2'h2;

  reg  [7:0]  ctrl_r;
  reg  [7:0]  cmd_r;
  reg  [7:0]  tx_hold_r;
  reg         tx_full_r;
  reg  [7:0]  rx_hold_r;
  reg         rx_full_r;
  reg         par_err_r;
  reg         frm_err_r;
  reg         ovr_r;
  reg         irq_r;
  reg  [7:0]  dout_r;
  reg         dout_oe_r;
  reg         dcd_q_r;
  reg         dsr_q_r;
  reg         rxc_q_r;
  reg  [15:0] div_cnt_r;
  reg         rxc_out_r;
  reg         tx_st_r;
  reg  [11:0] tx_sh_r;
  reg  [3:0]  tx_left_r;
  reg  [4:0]  tx_tick_r;
  reg  [1:0]  rx_st_r;
  reg  [4:0]  rx_tick_r;
  reg  [3:0]  rx_idx_r;
  reg  [8:0]  rx_sh_r;
  reg         rx_q_r;
  reg  [31:0] div_full;
  wire [15:0] div_sel;
  wire        acc;
  wire [1:0]  sel;
  wire        rd_data;
  wire        rd_stat;
  wire        wr_data;
  wire        wr_prst;
  wire        wr_cmd;
  wire        wr_ctrl;
  wire        gen_tick;
  wire        ext_tick;
  wire        tx_tick;
  wire        rx_tick;
  wire        rx_int_clk;
  wire [3:0]  wlen;
  wire        par_en;
  wire [1:0]  par_mode;
  wire        tx_load;
  wire        rx_push;
  wire        rx_ready;
  wire        q_valid;
  wire [9:0]  q_data;
  wire        q_pop;
  wire        ev_change;
  wire        ev_rxf;
  wire        ev_txe;
  wire [7:0]  status;
  wire [7:0]  tx_mask;
  wire        tx_par;
  wire [11:0] tx_frame;
  wire [3:0]  tx_bits;
  wire [7:0]  rx_data;
  wire        rx_par_exp;
  wire        rx_perr;

  assign acc     = chip_sel & bus_strobe;
  assign sel     = {register_select_high, register_select_low};
  assign rd_data = acc & read_not_write & (sel == `ACM_SEL_DATA);    // [RULE_17]
  assign rd_stat = acc & read_not_write & (sel == `ACM_SEL_STATUS);  // [RULE_17]
  assign wr_data = acc & ~read_not_write & (sel == `ACM_SEL_DATA);   // [RULE_17]
  assign wr_prst = acc & ~read_not_write & (sel == `ACM_SEL_STATUS); // [RULE_17]
  assign wr_cmd  = acc & ~read_not_write & (sel == `ACM_SEL_COMMAND);
  assign wr_ctrl = acc & ~read_not_write & (sel == `ACM_SEL_CONTROL);

  // Word length code 00 = 8 bits down to 11 = 5 bits
  assign wlen     = 4'h8 - {2'h0, ctrl_r[`ACM_CTL_WLEN_HI:`ACM_CTL_WLEN_LO]}; // [RULE_10]
  assign par_en   = cmd_r[`ACM_CMD_PAR_EN];
  assign par_mode = cmd_r[`ACM_CMD_PAR_HI:`ACM_CMD_PAR_LO];

  // Baud divisor table
  always @* begin
    case (ctrl_r[`ACM_CTL_BAUD_HI:`ACM_CTL_BAUD_LO]) // [RULE_08]
      4'h1:    div_full = `ACM_DIV(`ACM_BAUD100_1);
      4'h2:    div_full = `ACM_DIV(`ACM_BAUD100_2);
      4'h3:    div_full = `ACM_DIV(`ACM_BAUD100_3);
      4'h4:    div_full = `ACM_DIV(`ACM_BAUD100_4);
      4'h5:    div_full = `ACM_DIV(`ACM_BAUD100_5);
      4'h6:    div_full = `ACM_DIV(`ACM_BAUD100_6);
      4'h7:    div_full = `ACM_DIV(`ACM_BAUD100_7);
      4'h8:    div_full = `ACM_DIV(`ACM_BAUD100_8);
      4'h9:    div_full = `ACM_DIV(`ACM_BAUD100_9);
      4'hA:    div_full = `ACM_DIV(`ACM_BAUD100_10);
      4'hB:    div_full = `ACM_DIV(`ACM_BAUD100_11);
      4'hC:    div_full = `ACM_DIV(`ACM_BAUD100_12);
      4'hD:    div_full = `ACM_DIV(`ACM_BAUD100_13);
      4'hE:    div_full = `ACM_DIV(`ACM_BAUD100_14);
      4'hF:    div_full = `ACM_DIV(`ACM_BAUD100_15);
      default: div_full = 32'h00000000;
    endcase
  end
  // Largest divisor fits in 16 bits
  assign div_sel = div_full[15:0];

  assign gen_tick   = (div_sel != 16'h0000) && (div_cnt_r >= div_sel - 16'h0001);
  assign ext_tick   = receive_clock_pin_in & ~rxc_q_r; // [RULE_20]
  assign tx_tick    = (div_sel == 16'h0000) ? ext_tick : gen_tick;
  assign rx_int_clk = ctrl_r[`ACM_CTL_RXSRC];
  assign rx_tick    = rx_int_clk ? tx_tick : ext_tick;                    // [RULE_10]
  assign receive_clock_pin_oe  = rx_int_clk;                              // [RULE_09]
  assign receive_clock_pin_out = rxc_out_r;                               // [RULE_09]

  // Transmit frame, bit 0 first, start bit in position 0
  assign tx_mask  = tx_hold_r & (8'hFF >> (4'h8 - wlen));                 // [RULE_15]
  assign tx_par   = (par_mode == `ACM_PAR_ODD)  ? ~(^tx_mask) :
                    (par_mode == `ACM_PAR_EVEN) ? (^tx_mask) :
                    (par_mode == `ACM_PAR_MARK);
  assign tx_frame = par_en ?
                    ((12'hFFF << (wlen + 4'h1)) & ~(12'h001 << (wlen + 4'h1)))
                    | ({11'h000, tx_par} << (wlen + 4'h1)) | {3'h0, tx_mask, 1'b0} :
                    (12'hFFF << (wlen + 4'h1)) | {3'h0, tx_mask, 1'b0};   // [RULE_22]
  assign tx_bits  = 4'h2 + wlen + {3'h0, par_en} + {3'h0, ctrl_r[`ACM_CTL_STOP]};
  assign tx_load  = (tx_st_r == TX_IDLE) & tx_full_r & ~cts_n;            // [RULE_01]
  assign txd      = (tx_st_r == TX_SEND) ? tx_sh_r[0] : 1'b1;             // [RULE_22]

  // Receive character check
  assign rx_data    = rx_sh_r[7:0] & (8'hFF >> (4'h8 - wlen));            // [RULE_16]
  assign rx_par_exp = (par_mode == `ACM_PAR_ODD)  ? ~(^rx_data) :
                      (par_mode == `ACM_PAR_EVEN) ? (^rx_data) :
                      (par_mode == `ACM_PAR_MARK);
  assign rx_perr    = par_en & (rx_sh_r[wlen] != rx_par_exp);
  assign rx_push    = ~dcd_n & (rx_st_r == RX_BITS) & rx_tick
                      & (rx_tick_r == `ACM_TICKS_BIT - 5'h01)
                      & (rx_idx_r == wlen + {3'h0, par_en});
  assign q_pop      = q_valid & (~rx_full_r | rd_data);

  acm_fifo #(
    .WIDTH (10),
    .DEPTH (`ACM_FIFO_DEPTH),
    .AW    (`ACM_FIFO_AW)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (rx_push),
    .in_ready  (rx_ready),
    .in_data   ({~rxd, rx_perr, rx_data}),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  assign ev_change = cmd_r[`ACM_CMD_DTR] & ((dcd_n ^ dcd_q_r) | (dsr_n ^ dsr_q_r)); // [RULE_03]
  assign ev_rxf    = q_pop & ~cmd_r[`ACM_CMD_RXIRQ_DIS];
  assign ev_txe    = tx_load & (cmd_r[`ACM_CMD_TXC_HI:`ACM_CMD_TXC_LO] == `ACM_TXC_RTS_IRQ);
  assign status    = {irq_r, dsr_n, dcd_n, ~tx_full_r, rx_full_r, ovr_r, frm_err_r,
                      par_err_r}; // [RULE_05]
  assign data_out  = dout_r;
  assign data_oe   = dout_oe_r;
  assign irq_out   = 1'b0;
  assign irq_oe    = irq_r;                                                // [RULE_18]
  assign dtr_n     = ~cmd_r[`ACM_CMD_DTR];                                 // [RULE_02]
  assign rts_n     = (cmd_r[`ACM_CMD_TXC_HI:`ACM_CMD_TXC_LO] == `ACM_TXC_RTS_HIGH);

  // Register port, flags and interrupt
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= `ACM_CTRL_RST;                                          // [RULE_19]
      cmd_r     <= `ACM_CMD_RST;
      tx_hold_r <= 8'h00;
      tx_full_r <= 1'b0;
      rx_hold_r <= 8'h00;
      rx_full_r <= 1'b0;
      par_err_r <= 1'b0;
      frm_err_r <= 1'b0;
      ovr_r     <= 1'b0;
      irq_r     <= 1'b0;
      dout_r    <= 8'h00;
      dout_oe_r <= 1'b0;
      dcd_q_r   <= 1'b1;
      dsr_q_r   <= 1'b1;
    end else begin
      dcd_q_r   <= dcd_n;
      dsr_q_r   <= dsr_n;
      dout_oe_r <= acc & read_not_write;
      if (acc & read_not_write) begin
        case (sel)
          `ACM_SEL_DATA:    dout_r <= rx_hold_r;
          `ACM_SEL_STATUS:  dout_r <= status;
          `ACM_SEL_COMMAND: dout_r <= cmd_r;
          default:          dout_r <= ctrl_r;
        endcase
      end
      if (wr_ctrl) begin
        ctrl_r <= data_in;
      end
      if (wr_cmd) begin
        cmd_r <= data_in;
      end else if (wr_prst) begin
        cmd_r <= cmd_r & `ACM_CMD_PRST_MASK;
      end
      if (wr_data) begin
        tx_hold_r <= data_in;
        tx_full_r <= 1'b1;                                                 // [RULE_14]
      end else if (tx_load) begin
        tx_full_r <= 1'b0;                                                 // [RULE_14]
      end
      if (q_pop) begin
        rx_hold_r <= q_data[7:0];                                          // [RULE_16]
        rx_full_r <= 1'b1;                                                 // [RULE_13]
        par_err_r <= q_data[8];                                            // [RULE_11]
        frm_err_r <= q_data[9];                                            // [RULE_11]
        if (!(q_data[8] | q_data[9])) begin
          ovr_r <= 1'b0;                                                   // [RULE_11]
        end
      end else if (rd_data) begin
        rx_full_r <= 1'b0;                                                 // [RULE_13]
      end
      if (rx_push & ~rx_ready) begin
        ovr_r <= 1'b1;                                                     // [RULE_21]
      end else if (wr_prst & ~q_pop) begin
        ovr_r <= 1'b0;
      end
      // Error flags never reach the interrupt
      if (ev_change | ev_rxf | ev_txe) begin
        irq_r <= 1'b1;                                                     // [RULE_12]
      end else if (rd_stat) begin
        irq_r <= 1'b0;
      end
    end
  end

  // Baud generator and 16x clock output
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= 16'h0000;
      rxc_out_r <= 1'b0;
      rxc_q_r   <= 1'b0;
    end else begin
      rxc_q_r <= receive_clock_pin_in;
      if (gen_tick || div_sel == 16'h0000) begin
        div_cnt_r <= 16'h0000;
      end else begin
        div_cnt_r <= div_cnt_r + 16'h0001;
      end
      rxc_out_r <= (div_sel != 16'h0000) && (div_cnt_r < {1'b0, div_sel[15:1]}); // [RULE_09]
    end
  end

  // Transmitter
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r   <= TX_IDLE;
      tx_sh_r   <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_tick_r <= 5'h00;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          if (tx_load) begin
            tx_st_r   <= TX_SEND;
            tx_sh_r   <= tx_frame;
            tx_left_r <= tx_bits;
            tx_tick_r <= 5'h00;
          end
        end
        TX_SEND: begin
          if (cts_n) begin
            tx_st_r <= TX_IDLE;                                            // [RULE_01]
          end else if (tx_tick) begin
            if (tx_tick_r == `ACM_TICKS_BIT - 5'h01) begin
              tx_tick_r <= 5'h00;
              tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
              tx_left_r <= tx_left_r - 4'h1;
              if (tx_left_r == 4'h1) begin
                tx_st_r <= TX_IDLE;
              end
            end else begin
              tx_tick_r <= tx_tick_r + 5'h01;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Receiver; data-set-ready is not consulted here
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r   <= RX_IDLE;
      rx_tick_r <= 5'h00;
      rx_idx_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_q_r    <= 1'b1;
    end else begin
      rx_q_r <= rxd;
      if (dcd_n) begin
        rx_st_r <= RX_IDLE;                                                // [RULE_06] [RULE_04]
      end else begin
        case (rx_st_r)
          RX_IDLE: begin
            if (rx_q_r & ~rxd) begin
              rx_st_r   <= RX_START;
              rx_tick_r <= 5'h00;
            end
          end
          RX_START: begin
            if (rx_tick) begin
              if (rx_tick_r == `ACM_TICKS_HALF - 5'h01) begin
                rx_tick_r <= 5'h00;
                rx_idx_r  <= 4'h0;
                rx_sh_r   <= 9'h000;
                rx_st_r   <= rxd ? RX_IDLE : RX_BITS;                      // [RULE_22]
              end else begin
                rx_tick_r <= rx_tick_r + 5'h01;
              end
            end
          end
          RX_BITS: begin
            if (rx_tick) begin
              if (rx_tick_r == `ACM_TICKS_BIT - 5'h01) begin
                rx_tick_r <= 5'h00;
                if (rx_push) begin
                  rx_st_r <= RX_IDLE;
                end else begin
                  rx_sh_r[rx_idx_r] <= rxd;                                // [RULE_16]
                  rx_idx_r          <= rx_idx_r + 4'h1;
                end
              end else begin
                rx_tick_r <= rx_tick_r + 5'h01;
              end
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end
endmodule // acm_adapter

// file: test/acm_modem_model.sv
// Purpose: Modem side of the serial link: sends frames on rxd, decodes txd.
// Assumes: One serial bit is 64 clk cycles (16 ticks of 4 cycles).
// Notes:   Decoder handles 8 data bits, no parity, one stop bit.
`timescale 1ns/10ps
module acm_modem_model (
  input  wire clk, // Bench clock
  input  wire txd, // Serial data from the adapter
  output reg  rxd  // Serial data to the adapter
);
  integer   frames = 0;
  integer   i;
  reg [7:0] got;
  initial rxd = 1'b1;
  // Low start, LSB first, high stop, line left high
  task send(input [7:0] b, input integer nb);
    integer k;
    begin
      @(posedge clk) #2 rxd = 1'b0;
      repeat (64) @(posedge clk);
      for (k = 0; k < nb; k = k + 1) begin
        #2 rxd = b[k];
        repeat (64) @(posedge clk);
      end
      #2 rxd = 1'b1;
      repeat (64) @(posedge clk);
    end
  endtask
  // Samples each bit at its middle
  always begin
    @(negedge txd);
    repeat (32) @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      repeat (64) @(posedge clk);
      got[i] = txd;
    end
    repeat (64) @(posedge clk);
    frames = frames + 1;
  end
endmodule // acm_modem_model

// file: test/acm_adapter_sva.sv
// Purpose: Port assertions for acm_adapter.
// Assumes: One clock; rst_b asynchronous, active low.
// Notes:   Bound to every acm_adapter below.
`timescale 1ns/10ps
module acm_adapter_sva (
  input wire       clk, rst_b, chip_sel, bus_strobe, read_not_write, // Bus
  input wire       register_select_low, register_select_high,        // Select
  input wire [7:0] data_in,                                          // Write data
  input wire       data_oe, irq_out, irq_oe, txd, dtr_n,             // Outputs
  input wire       cts_n, dsr_n, dcd_n, receive_clock_pin_oe         // Pins
);
  wire       acc = chip_sel & bus_strobe;
  wire [1:0] sel = {register_select_high, register_select_low};
  reg        cmd0_r;
  // Tracks command bit 0, which programmed reset also clears
  always @(posedge clk or negedge rst_b)
    if (!rst_b) cmd0_r <= 1'b0;
    else if (acc & !read_not_write & sel == 2'h2) cmd0_r <= data_in[0];
    else if (acc & !read_not_write & sel == 2'h1) cmd0_r <= 1'b0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_dtr; acc && !read_not_write && sel == 2'h2 |=> dtr_n == !$past(data_in[0]); endproperty
  a_dtr: assert property (p_dtr) else $error("dtr_n differs from command bit");
  property p_rd; acc && read_not_write |=> data_oe; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_oe; data_oe |-> $past(acc && read_not_write); endproperty
  a_oe: assert property (p_oe) else $error("data bus driven without read");
  property p_od; irq_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("interrupt pin driven high");
  property p_rck; acc && !read_not_write && sel == 2'h3 |=>
    receive_clock_pin_oe == $past(data_in[4]); endproperty
  a_rck: assert property (p_rck) else $error("receive clock pin direction wrong");
  property p_cts; cts_n [*3] |-> txd; endproperty
  a_cts: assert property (p_cts) else $error("transmit while clear-to-send high");
  property p_dsr; cmd0_r && $changed(dsr_n) |-> ##[0:3] irq_oe; endproperty
  a_dsr: assert property (p_dsr) else $error("no interrupt on ready change");
  property p_dcd; cmd0_r && $changed(dcd_n) |-> ##[0:3] irq_oe; endproperty
  a_dcd: assert property (p_dcd) else $error("no interrupt on carrier change");
  c_irq: cover property ($rose(irq_oe));
  c_rd: cover property (data_oe);
  c_tx: cover property ($fell(txd));
endmodule // acm_adapter_sva
bind acm_adapter acm_adapter_sva i_sva (.*);

// file: test/acm_adapter_tb_top.sv
// Purpose: Register-level tests of acm_adapter against a modem model.
// Assumes: External 16x clock of four clk cycles; serial bit of 64 cycles.
// Notes:   Inputs change 2 ns after the rising edge, except the 16x clock ph[1], which changes on the edge.
`timescale 1ns/10ps
module acm_adapter_tb_top;
  reg       clk = 1'b0, rst_b = 1'b0, cs = 1'b0, stb = 1'b0, rnw = 1'b0;
  reg       cts_n = 1'b0, dsr_n = 1'b0, dcd_n = 1'b0;
  reg [1:0] sel = 2'h0, ph = 2'h0;
  reg [7:0] din = 8'h00;
  wire [7:0] dout;
  wire      data_oe, irq_out, irq_oe, txd, rxd, rts_n, dtr_n, rck_out, rck_oe;
  integer   errors = 0, checked = 0, n;
  always #12.5 clk = ~clk;
  always @(posedge clk) ph <= ph + 2'h1;
  acm_adapter i_acm_adapter (.clk(clk), .rst_b(rst_b), .chip_sel(cs), .bus_strobe(stb),
    .read_not_write(rnw), .register_select_low(sel[0]), .register_select_high(sel[1]),
    .data_in(din), .data_out(dout), .data_oe(data_oe), .irq_out(irq_out), .irq_oe(irq_oe),
    .txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .rts_n(rts_n),
    .dtr_n(dtr_n), .receive_clock_pin_in(ph[1]), .receive_clock_pin_out(rck_out),
    .receive_clock_pin_oe(rck_oe));
  acm_modem_model i_acm_modem_model (.clk(clk), .txd(txd), .rxd(rxd));
  task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task acc(input r, input [1:0] s, input [7:0] d);
    begin
      @(posedge clk) #2;
      cs = 1'b1; stb = 1'b1; rnw = r; sel = s; din = d;
      @(posedge clk) #2;
      cs = 1'b0; stb = 1'b0;
    end
  endtask
  task rd(input [1:0] s, input [7:0] exp);
    begin
      acc(1'b1, s, 8'h00);
      chk("oe", 8'h01, {7'h00, data_oe});
      chk("rdata", exp, dout);
    end
  endtask
  task wait_fr(input integer f);
    begin
      n = 0;
      while (i_acm_modem_model.frames != f && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
      #2 chk("frames", 8'h01, {7'h00, i_acm_modem_model.frames == f});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #500000;
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    #2 rst_b = 1'b1;
    rd(2'h3, 8'h00);
    rd(2'h2, 8'h00);
    chk("dtr", 8'h01, {7'h00, dtr_n});
    chk("rts", 8'h01, {7'h00, rts_n});
    acc(1'b0, 2'h2, 8'h01);
    chk("dtr", 8'h00, {7'h00, dtr_n});
    rd(2'h2, 8'h01);
    $display("test registers ended");
    acc(1'b0, 2'h0, 8'hA5);
    wait_fr(1);
    chk("tx", 8'hA5, i_acm_modem_model.got);
    cts_n = 1'b1;
    acc(1'b0, 2'h0, 8'h5A);
    repeat (700) @(posedge clk);
    #2 chk("held", 8'h01, {7'h00, i_acm_modem_model.frames == 1});
    cts_n = 1'b0;
    wait_fr(2);
    chk("tx", 8'h5A, i_acm_modem_model.got);
    $display("test transmit ended");
    i_acm_modem_model.send(8'h3C, 8);
    repeat (40) @(posedge clk);
    rd(2'h1, 8'h98);
    rd(2'h0, 8'h3C);
    rd(2'h1, 8'h10);
    acc(1'b0, 2'h3, 8'h20);
    i_acm_modem_model.send(8'hFF, 7);
    repeat (40) @(posedge clk);
    rd(2'h0, 8'h7F);
    acc(1'b0, 2'h2, 8'h21);
    i_acm_modem_model.send(8'hC0, 8);
    repeat (40) @(posedge clk);
    rd(2'h0, 8'h40);
    rd(2'h1, 8'h91);
    $display("test receive ended");
    dsr_n = 1'b1;
    repeat (4) @(posedge clk);
    #2 chk("irq", 8'h01, {7'h00, irq_oe});
    rd(2'h1, 8'hD1);
    dcd_n = 1'b1;
    repeat (4) @(posedge clk);
    rd(2'h1, 8'hF1);
    i_acm_modem_model.send(8'h55, 8);
    repeat (40) @(posedge clk);
    rd(2'h1, 8'h71);
    acc(1'b0, 2'h3, 8'h00);
    acc(1'b0, 2'h0, 8'h81);
    wait_fr(3);
    chk("tx", 8'h81, i_acm_modem_model.got);
    acc(1'b0, 2'h3, 8'h1F);
    chk("rckoe", 8'h01, {7'h00, rck_oe});
    n = 0;
    repeat (130) begin
      @(posedge clk) #2 n = n + rck_out;
    end
    chk("rckhigh", 8'h41, n[7:0]);
    acc(1'b0, 2'h1, 8'hFF);
    chk("dtr", 8'h01, {7'h00, dtr_n});
    $display("test modem lines ended");
    print_verdict;
  end
endmodule // acm_adapter_tb_top
